// ---- hw/fcd_dma.sv ----
// Four-channel DMA control: register file on AXI4-Lite, channel arbiter,
// transfer sequencer, chain fetch and CPU access throttling.
// Assumes the data path moves one word per beat and shares clk.
`default_nettype none

// How it works
// - Once a transfer runs, CPU memory reads wait for a boundary hit or its end.
// - Each boundary hit admits one CPU memory transaction; writes may post.
// - With a posted memory write, other memory accesses wait for boundary or end.
// - CPU reads to PCI space stall until the transfer is over.
// - CPU PCI writes post; while posted, every other CPU access stalls.
// - Four independent register sets; any set is accessible while another runs.
// - While a channel runs, control writes touch only reset and hold bits.
// - Byte count of zero means one full megabyte.
// - Boundary code selects 32 bytes up to 512K, zero disables.
// - Abort bit ends the transfer, resets the channel, then clears itself.
// - Space select picks PCI memory space or I/O space.
// - Step bit advances the PCI address, otherwise start address is reused.
// - Hold bit pauses after the current cycle and resumes when cleared.
// - Start bit launches when buses are free; clears at completion or abort.
// - Direction bit picks PCI to memory or memory to PCI.
// - Completion flag raised only with enable bit and global interrupts on.
// - Bit 31 reads one while the channel transfer is in progress.
// - Arbitration bits 11:8 enable chaining per channel.
// - Chaining stops when all chaining enables are zero.
// - Bits 13:12 pick the group grant order; rearbitrate after each structure.
// - Chain on: fetch next structure and start it, flag only at the end.
// - Zero next pointer ends the chain; each structure is four words.
// - FIFO of eight words: drain from four, stop filling at full, refill at half.
module fcd_dma (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite register slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// CPU side
	input wire fcd_pkg::fcd_cpu_in_type cpu_in,
	output logic cpu_ack_n,
	output logic [3:0] done_status,
	// Data path side
	input wire fcd_pkg::fcd_path_in_type path_in,
	output fcd_pkg::fcd_path_out_type path_out
);

	typedef struct packed {
		logic [3:0][31:0] ctl;
		logic [3:0][31:0] mem;
		logic [3:0][31:0] pci;
		logic [3:0][31:0] nxt;
		logic [5:0] arb;
		fcd_pkg::fcd_state_type st;
		logic [1:0] ch;
		logic [2:0] slot;
		logic [31:0] cmem;
		logic [31:0] cpci;
		logic [18:0] fill_left;
		logic [18:0] drain_left;
		logic [3:0] level;
		logic fill_en;
		logic window;
		logic [1:0] didx;
		fcd_pkg::fcd_path_out_type po;
		logic ack_n;
		logic [3:0] done;
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic rvalid;
		logic aw_got;
		logic w_got;
		logic [7:0] awa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} fcd_regs_type;

	fcd_regs_type r;
	fcd_regs_type n;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction : merge

	// Grant order across groups A (0,1) and B (2,3)
	function automatic logic [1:0] seq_ch(input logic [1:0] mode, input logic [2:0] slot);
		logic [1:0] c;
		case (mode)
			2'b01: c = (slot < 3'd4) ? {1'b0, slot[0]} : {1'b1, slot[0]};
			2'b10: c = (slot < 3'd4) ? {1'b1, slot[0]} : {1'b0, slot[0]};
			default: c = slot[1:0];
		endcase
		return c;
	endfunction : seq_ch

	////////////////////////////////////////////////////////////////////////////
	// Next state

	logic [31:0] v;
	logic hit;
	logic [1:0] c;
	logic [20:0] nbytes;
	logic [31:0] bmask;
	logic [31:0] addr_next;
	logic memb;
	logic pcib;
	logic dma_act;
	logic hold;
	logic [1:0] cur;

	always_comb begin
		n = r;
		v = '0;
		hit = 1'b0;
		c = '0;
		nbytes = '0;
		bmask = '0;
		addr_next = '0;
		cur = r.ch;
		n.done = '0;
		n.ack_n = 1'b1;
		dma_act = (r.st != fcd_pkg::ST_IDLE);
		memb = r.po.to_memory ? path_in.drain_beat : path_in.fill_beat;
		pcib = r.po.to_memory ? path_in.fill_beat : path_in.drain_beat;
		hold = r.ctl[cur][fcd_pkg::BIT_HOLD];

		// Bus channels accept independently, write acts once both are in
		if (s_axi_awvalid && r.awready) begin
			n.awready = 1'b0;
			n.aw_got = 1'b1;
			n.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			n.wready = 1'b0;
			n.w_got = 1'b1;
			n.wd = s_axi_wdata;
			n.ws = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end
		if (r.aw_got && r.w_got) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			for (int i = 0; i < fcd_pkg::NCH; i++) begin
				if (r.awa == fcd_pkg::CTL_OFF[i]) begin
					hit = 1'b1;
					v = merge(r.ctl[i], r.wd, r.ws);
					if (r.ctl[i][fcd_pkg::BIT_BUSY]) begin
						n.ctl[i][fcd_pkg::BIT_RST] = v[fcd_pkg::BIT_RST];
						n.ctl[i][fcd_pkg::BIT_HOLD] = v[fcd_pkg::BIT_HOLD];
					end else begin
						n.ctl[i] = {1'b0, v[30:0]};
					end
				end
				if (r.awa == fcd_pkg::MEM_OFF[i]) begin
					hit = 1'b1;
					n.mem[i] = merge(r.mem[i], r.wd, r.ws);
				end
				if (r.awa == fcd_pkg::PCI_OFF[i]) begin
					hit = 1'b1;
					n.pci[i] = merge(r.pci[i], r.wd, r.ws);
				end
				if (r.awa == fcd_pkg::NXT_OFF[i]) begin
					hit = 1'b1;
					n.nxt[i] = merge(r.nxt[i], r.wd, r.ws);
				end
			end
			if (r.awa == fcd_pkg::ARB_OFF) begin
				hit = 1'b1;
				v = merge({18'h0, r.arb, 8'h00}, r.wd, r.ws);
				n.arb = v[fcd_pkg::ARB_MSB:fcd_pkg::ARB_LSB];
			end
			hit = hit || r.awa == fcd_pkg::WORDS_OFF || r.awa == fcd_pkg::CMEM_OFF || r.awa == fcd_pkg::CPCI_OFF;
			n.bresp = hit ? fcd_pkg::RESP_OKAY : fcd_pkg::RESP_SLVERR;
		end

		// Read answer one cycle after the address is taken
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
		if (s_axi_arvalid && r.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = '0;
			n.rresp = fcd_pkg::RESP_OKAY;
			case (s_axi_araddr)
				fcd_pkg::ARB_OFF: n.rdata = {18'h0, r.arb, fcd_pkg::ARB_RESET[7:0]};
				fcd_pkg::WORDS_OFF: n.rdata = {13'h0, r.drain_left};
				fcd_pkg::CMEM_OFF: n.rdata = r.cmem;
				fcd_pkg::CPCI_OFF: n.rdata = r.cpci;
				default: n.rresp = fcd_pkg::RESP_SLVERR;
			endcase
			for (int i = 0; i < fcd_pkg::NCH; i++) begin
				if (s_axi_araddr == fcd_pkg::CTL_OFF[i]) begin
					n.rdata = r.ctl[i];
					n.rresp = fcd_pkg::RESP_OKAY;
				end
				if (s_axi_araddr == fcd_pkg::MEM_OFF[i]) begin
					n.rdata = r.mem[i];
					n.rresp = fcd_pkg::RESP_OKAY;
				end
				if (s_axi_araddr == fcd_pkg::PCI_OFF[i]) begin
					n.rdata = r.pci[i];
					n.rresp = fcd_pkg::RESP_OKAY;
				end
				if (s_axi_araddr == fcd_pkg::NXT_OFF[i]) begin
					n.rdata = r.nxt[i];
					n.rresp = fcd_pkg::RESP_OKAY;
				end
			end
		end

		// CPU throttling; ack is a one-cycle low pulse per request
		if (cpu_in.req && r.ack_n && !cpu_in.pfifo_posted) begin
			if (cpu_in.to_pci) begin
				n.ack_n = dma_act && !cpu_in.wr;
			end else if (!dma_act) begin
				n.ack_n = 1'b0;
			end else if (r.window) begin
				n.ack_n = 1'b0;
				n.window = 1'b0;
			end else if (cpu_in.wr && !cpu_in.wfifo_posted) begin
				n.ack_n = 1'b0;
			end else begin
				n.ack_n = 1'b1;
			end
		end

		// Transfer sequencer
		case (r.st)
			fcd_pkg::ST_IDLE: begin
				c = seq_ch(r.arb[5:4], r.slot);
				n.slot = (r.slot == ((r.arb[5:4] == 2'b01 || r.arb[5:4] == 2'b10) ? 3'd5 : 3'd3)) ? 3'd0 : r.slot + 3'd1;
				if (r.ctl[c][fcd_pkg::BIT_GO] && !r.ctl[c][fcd_pkg::BIT_RST] && path_in.buses_free) begin
					nbytes = {r.ctl[c][fcd_pkg::BC_MSB:0] == 20'h0, r.ctl[c][fcd_pkg::BC_MSB:0]};
					n.st = fcd_pkg::ST_RUN;
					n.ch = c;
					n.ctl[c][fcd_pkg::BIT_BUSY] = 1'b1;
					n.cmem = r.mem[c];
					n.cpci = r.pci[c];
					n.fill_left = 19'((nbytes + 21'h3) >> 2);
					n.drain_left = 19'((nbytes + 21'h3) >> 2);
					n.level = '0;
					n.fill_en = 1'b1;
					n.window = 1'b0;
					n.po.channel = c;
					n.po.to_memory = r.ctl[c][fcd_pkg::BIT_DIR];
					n.po.pci_space = r.ctl[c][fcd_pkg::BIT_SPACE];
					n.po.fill_req = !r.ctl[c][fcd_pkg::BIT_HOLD];
				end
			end
			fcd_pkg::ST_RUN: begin
				if (pcib && r.ctl[cur][fcd_pkg::BIT_STEP]) begin
					n.cpci = r.cpci + fcd_pkg::WORD_BYTES;
				end
				if (memb) begin
					addr_next = r.cmem + fcd_pkg::WORD_BYTES;
					bmask = (fcd_pkg::BOUND_BASE << r.ctl[cur][fcd_pkg::BND_LSB +: 4]) - 32'h1;
					n.cmem = addr_next;
					if (r.ctl[cur][fcd_pkg::BND_LSB +: 4] != 4'h0 && (addr_next & bmask) == 32'h0) begin
						n.window = 1'b1;
					end
				end
				n.level = r.level + {3'h0, path_in.fill_beat} - {3'h0, path_in.drain_beat};
				if (path_in.fill_beat) begin
					n.fill_left = r.fill_left - 19'h1;
				end
				if (path_in.drain_beat) begin
					n.drain_left = r.drain_left - 19'h1;
				end
				// Hysteresis keeps the filling bus from thrashing around full
				if (n.level == fcd_pkg::FIFO_DEPTH) begin
					n.fill_en = 1'b0;
				end else if (n.level <= fcd_pkg::FIFO_HALF) begin
					n.fill_en = 1'b1;
				end
				n.po.fill_req = !hold && n.fill_en && n.fill_left != 19'h0;
				n.po.drain_req = !hold && (n.level >= fcd_pkg::FIFO_HALF
					|| (n.fill_left == 19'h0 && n.level != 4'h0));
				if (n.drain_left == 19'h0) begin
					n.po.fill_req = 1'b0;
					n.po.drain_req = 1'b0;
					n.window = 1'b0;
					if (r.arb[cur] && r.arb[3:0] != 4'h0 && r.nxt[cur] != 32'h0) begin
						n.st = fcd_pkg::ST_FETCH;
						n.didx = '0;
						n.po.desc_req = 1'b1;
						n.po.desc_addr = r.nxt[cur];
					end else begin
						n.st = fcd_pkg::ST_IDLE;
						n.ctl[cur][fcd_pkg::BIT_GO] = 1'b0;
						n.ctl[cur][fcd_pkg::BIT_BUSY] = 1'b0;
						n.done[cur] = r.ctl[cur][fcd_pkg::BIT_DONE_EN] && cpu_in.irq_en;
					end
				end
			end
			fcd_pkg::ST_FETCH: begin
				if (path_in.desc_beat) begin
					n.didx = r.didx + 2'h1;
					n.po.desc_addr = r.po.desc_addr + fcd_pkg::WORD_BYTES;
					case (r.didx)
						2'h0: n.mem[cur] = path_in.desc_word;
						2'h1: n.pci[cur] = path_in.desc_word;
						2'h2: n.nxt[cur] = path_in.desc_word;
						default: begin
							// Fetched structure always starts; its abort bit is dropped
							n.ctl[cur] = {1'b1, path_in.desc_word[30:29], 1'b1, path_in.desc_word[27:25],
								1'b0, path_in.desc_word[23:0]};
						end
					endcase
					if (r.didx == fcd_pkg::DESC_LAST) begin
						n.st = fcd_pkg::ST_IDLE;
						n.po.desc_req = 1'b0;
					end
				end
			end
			default: n.st = fcd_pkg::ST_IDLE;
		endcase

		// Channel abort: requests drop now, beats already in flight finish outside
		for (int i = 0; i < fcd_pkg::NCH; i++) begin
			if (r.ctl[i][fcd_pkg::BIT_RST]) begin
				if (dma_act && cur == 2'(i)) begin
					n.st = fcd_pkg::ST_IDLE;
					n.po.fill_req = 1'b0;
					n.po.drain_req = 1'b0;
					n.po.desc_req = 1'b0;
					n.window = 1'b0;
				end
				n.ctl[i][fcd_pkg::BIT_RST] = 1'b0;
				n.ctl[i][fcd_pkg::BIT_GO] = 1'b0;
				n.ctl[i][fcd_pkg::BIT_BUSY] = 1'b0;
				n.ctl[i][fcd_pkg::BIT_HOLD] = 1'b0;
			end
		end
		n.po.mem_addr = n.cmem;
		n.po.pci_addr = n.cpci;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
			r.ack_n <= 1'b1;
			r.arb <= fcd_pkg::ARB_RESET[fcd_pkg::ARB_MSB:fcd_pkg::ARB_LSB];
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bresp = r.bresp;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rvalid = r.rvalid;
	assign cpu_ack_n = r.ack_n;
	assign done_status = r.done;
	assign path_out = r.po;

endmodule : fcd_dma

`default_nettype wire

// ---- hw/fcd_pkg.sv ----
// Constants, register map and carrier types for the four-channel DMA control block.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
`default_nettype none

package fcd_pkg;
	localparam int NCH = 4;
	// Register byte offsets
	localparam logic [7:0] CTL_OFF [NCH] = '{8'h38, 8'h44, 8'hA4, 8'hB0};
	localparam logic [7:0] MEM_OFF [NCH] = '{8'h3C, 8'h48, 8'hA8, 8'hB4};
	localparam logic [7:0] PCI_OFF [NCH] = '{8'h40, 8'h4C, 8'hAC, 8'hB8};
	localparam logic [7:0] NXT_OFF [NCH] = '{8'hBC, 8'hC0, 8'hC4, 8'hC8};
	localparam logic [7:0] ARB_OFF = 8'h80;
	localparam logic [7:0] WORDS_OFF = 8'h64;
	localparam logic [7:0] CMEM_OFF = 8'h68;
	localparam logic [7:0] CPCI_OFF = 8'h6C;
	// Reset values
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	localparam logic [31:0] ARB_RESET = 32'h0000_0009;
	// Control register fields
	localparam int BC_MSB = 19;
	localparam int BND_LSB = 20;
	localparam int BIT_RST = 24;
	localparam int BIT_SPACE = 25;
	localparam int BIT_STEP = 26;
	localparam int BIT_HOLD = 27;
	localparam int BIT_GO = 28;
	localparam int BIT_DIR = 29;
	localparam int BIT_DONE_EN = 30;
	localparam int BIT_BUSY = 31;
	// Arbitration register fields (bits 13:8 are stored)
	localparam int ARB_LSB = 8;
	localparam int ARB_MSB = 13;
	// Data path figures
	localparam logic [3:0] FIFO_DEPTH = 4'h8;
	localparam logic [3:0] FIFO_HALF = 4'h4;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] BOUND_BASE = 32'h0000_0010;
	localparam logic [1:0] DESC_LAST = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_FETCH = 2'b10
	} fcd_state_type;

	// CPU side requests and FIFO status, same clock
	typedef struct packed {
		logic req;
		logic wr;
		logic to_pci;
		logic wfifo_posted;
		logic pfifo_posted;
		logic irq_en;
	} fcd_cpu_in_type;

	// Data path handshakes, same clock
	typedef struct packed {
		logic buses_free;
		logic fill_beat;
		logic drain_beat;
		logic desc_beat;
		logic [31:0] desc_word;
	} fcd_path_in_type;

	typedef struct packed {
		logic fill_req;
		logic drain_req;
		logic to_memory;
		logic pci_space;
		logic [31:0] mem_addr;
		logic [31:0] pci_addr;
		logic desc_req;
		logic [31:0] desc_addr;
		logic [1:0] channel;
	} fcd_path_out_type;
endpackage : fcd_pkg

`default_nettype wire

// ---- dv/fcd_checker.sv ----
// Port checker for fcd_dma: CPU throttling, FIFO level, completion.
// Bound to every fcd_dma instance; sees only its ports.
`default_nettype none

module fcd_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// CPU side
	input wire fcd_pkg::fcd_cpu_in_type cpu_in,
	input wire logic cpu_ack_n,
	input wire logic [3:0] done_status,
	// Data path side
	input wire fcd_pkg::fcd_path_in_type path_in,
	input wire fcd_pkg::fcd_path_out_type path_out
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////
	// Shadow FIFO level, counted from the beats only
	logic [4:0] lvl_reg;
	logic [4:0] lvl_next;
	always_comb begin
		lvl_next = lvl_reg + 5'(path_in.fill_beat) - 5'(path_in.drain_beat);
	end
	always_ff @(posedge clk) begin
		if (rst)
			lvl_reg <= 5'h00;
		else
			lvl_reg <= lvl_next;
	end

	property p_ack_pulse;
		!cpu_ack_n |=> cpu_ack_n;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause;
		!cpu_ack_n |-> $past(cpu_in.req) && !$past(cpu_in.pfifo_posted);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request or while posted");
	property p_pci_rd;
		(path_out.fill_req || path_out.drain_req) && cpu_in.req && cpu_in.to_pci && !cpu_in.wr |=> cpu_ack_n;
	endproperty
	a_pci_rd: assert property (p_pci_rd) else $error("PCI read admitted during transfer");
	property p_lvl_max;
		lvl_reg <= 5'h08;
	endproperty
	a_lvl_max: assert property (p_lvl_max) else $error("FIFO filled past eight words");
	property p_drain_data;
		path_out.drain_req |-> lvl_reg != 5'h00;
	endproperty
	a_drain_data: assert property (p_drain_data) else $error("drain requested from empty FIFO");
	property p_done_pulse;
		done_status != 4'h0 |-> $past(cpu_in.irq_en) ##1 done_status == 4'h0;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("completion flag wrong");
	property p_done_quiet;
		done_status != 4'h0 |-> !path_out.fill_req && !path_out.drain_req;
	endproperty
	a_done_quiet: assert property (p_done_quiet) else $error("requests left up at completion");
	property p_cfg_stable;
		path_out.fill_req && $past(path_out.fill_req) |-> $stable(path_out.to_memory) && $stable(path_out.pci_space);
	endproperty
	a_cfg_stable: assert property (p_cfg_stable) else $error("direction or space moved in run");
endmodule : fcd_checker

bind fcd_dma fcd_checker u_chk (.clk(clk), .rst(rst), .cpu_in(cpu_in), .cpu_ack_n(cpu_ack_n),
	.done_status(done_status), .path_in(path_in), .path_out(path_out));

`default_nettype wire

// ---- dv/fcd_path_model.sv ----
// Data path stand-in for fcd_dma: word beats and descriptor words.
// Shares clk; beats only while the matching request is high.
`default_nettype none

module fcd_path_model (
	// Clock, reset and pacing
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	// Block side
	input wire fcd_pkg::fcd_path_out_type po,
	output fcd_pkg::fcd_path_in_type pi,
	// Observation
	output int desc_cnt,
	output logic [31:0] desc_first
);
	// Descriptor at 0x100: memory, PCI, next (end), control
	localparam logic [31:0] TBL [4] = '{32'h0000_0200, 32'h0000_0300, 32'h0000_0000, 32'h6000_0010};
	logic [1:0] tick_reg;
	logic ok;

	////////////////////////////////////////////////////////////
	assign ok = !slow || tick_reg == 2'h0;
	always_comb begin
		pi.buses_free = 1'b1;
		pi.fill_beat = po.fill_req && ok;
		pi.drain_beat = po.drain_req && ok;
		pi.desc_beat = po.desc_req && ok;
		// Off-beat word is inverted so a stale sample cannot pass
		pi.desc_word = pi.desc_beat ? TBL[po.desc_addr[3:2]] : ~TBL[po.desc_addr[3:2]];
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_reg <= 2'h0;
			desc_cnt <= 0;
			desc_first <= 32'h0;
		end else begin
			tick_reg <= tick_reg + 2'h1;
			if (pi.desc_beat && desc_cnt == 0)
				desc_first <= po.desc_addr;
			if (pi.desc_beat)
				desc_cnt <= desc_cnt + 1;
		end
	end
endmodule : fcd_path_model

`default_nettype wire

// ---- dv/tb_fcd_dma.sv ----
// Bench for fcd_dma: registers, CPU throttling, hold, chaining, abort.
// Acts as AXI4-Lite master and CPU; fcd_path_model plays the data path.
`default_nettype none

module tb_fcd_dma;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] GO = 32'h1000_0000;
	localparam logic [31:0] TOMEM = 32'h2000_0000;
	localparam logic [31:0] DONE_EN = 32'h4000_0000;
	// Cases: posted, to_pci, write, boundary 32, ack only after done
	localparam logic [4:0] TC [7] = '{5'h0B, 5'h01, 5'h02, 5'h04, 5'h15, 5'h16, 5'h0C};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, ack_n;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd, c, w, dfirst;
	logic [3:0] done;
	fcd_pkg::fcd_cpu_in_type cpu = '0;
	fcd_pkg::fcd_path_in_type pin;
	fcd_pkg::fcd_path_out_type pout;
	int error_cnt = 0;
	int checked = 0;
	int ndone [4];
	int dcnt, n, lat, d0;

	always #12.5 clk = ~clk;

	fcd_dma dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_in(cpu), .cpu_ack_n(ack_n),
		.done_status(done), .path_in(pin), .path_out(pout));
	fcd_path_model partner (.clk(clk), .rst(rst), .slow(slow), .po(pout), .pi(pin), .desc_cnt(dcnt),
		.desc_first(dfirst));

	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (done[i] === 1'b1)
				ndone[i] <= ndone[i] + 1;
		end
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic lim(input int k);
		if (k > 3000) begin
			error_cnt++;
			$display("[ERR] %0t wait limit", $time);
			test_done();
		end
	endtask : lim

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int k;
		logic awl;
		logic wl;
		k = 0;
		awl = 1'b1;
		wl = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (bvalid !== 1'b1) begin
			@(posedge clk);
			k++;
			lim(k);
			if (awl && awready === 1'b1) begin
				awl = 1'b0;
				awvalid <= 1'b0;
			end
			if (wl && wready === 1'b1) begin
				wl = 1'b0;
				wvalid <= 1'b0;
			end
		end
		rsp = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (rvalid !== 1'b1) begin
			@(posedge clk);
			k++;
			lim(k);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : axr

	// Programs a channel and returns once its transfer has launched
	task automatic start(input int ch, input logic [31:0] ctl, input logic [31:0] mem);
		int k;
		axw(fcd_pkg::MEM_OFF[ch], mem);
		axw(fcd_pkg::PCI_OFF[ch], 32'h0000_1000);
		// Bus mastering is taken as already enabled on the PCI side
		axw(fcd_pkg::CTL_OFF[ch], ctl);
		for (k = 0; pout.fill_req !== 1'b1; k++) begin
			@(posedge clk);
			lim(k);
		end
	endtask : start

	task automatic wait_idle(input int ch);
		int k;
		k = 0;
		do begin
			axr(fcd_pkg::CTL_OFF[ch]);
			k++;
			lim(k);
		end while (rd[31] !== 1'b0);
		repeat (2) @(posedge clk);
	endtask : wait_idle

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		cpu.irq_en <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			axr(fcd_pkg::CTL_OFF[i]);
			chk(rd, fcd_pkg::CTL_RESET);
			axw(fcd_pkg::MEM_OFF[i], 32'h0000_0100 << i);
			axr(fcd_pkg::MEM_OFF[i]);
			chk(rd, 32'h0000_0100 << i);
		end
		axr(fcd_pkg::ARB_OFF);
		chk(rd, fcd_pkg::ARB_RESET);
		axr(8'h00);
		chk(32'(rsp), 32'(fcd_pkg::RESP_SLVERR));
		chk(rd, 32'h0);
		axw(8'h00, 32'hFFFF_FFFF);
		chk(32'(rsp), 32'(fcd_pkg::RESP_SLVERR));
		axw(fcd_pkg::CTL_OFF[0], 32'h8000_0000);
		axr(fcd_pkg::CTL_OFF[0]);
		chk(rd, 32'h0);
		// CPU access while a 64-byte transfer runs
		for (int i = 0; i < 7; i++) begin
			n = ndone[0];
			c = GO | TOMEM | DONE_EN | (i[0] ? 32'h0200_0000 : 32'h0) | (TC[i][1] ? 32'h0010_0000 : 32'h0) | 32'd64;
			start(0, c, 32'h0);
			chk(32'(pout.pci_space), 32'(i[0]));
			chk(32'(pout.to_memory), 32'h1);
			chk(32'(pout.channel), 32'h0);
			cpu.req <= 1'b1;
			cpu.to_pci <= TC[i][3];
			cpu.wr <= TC[i][2];
			cpu.wfifo_posted <= TC[i][4];
			for (lat = 0; ack_n !== 1'b0; lat++) begin
				@(posedge clk);
				lim(lat);
			end
			cpu.req <= 1'b0;
			repeat (2) @(posedge clk);
			chk(32'(ndone[0] != n), 32'(TC[i][0]));
			wait_idle(0);
			chk(rd, c & ~GO);
			chk(ndone[0] - n, 1);
			axr(fcd_pkg::CPCI_OFF);
			chk(rd, 32'h0000_1000);
		end
		// A posted PCI write blocks a CPU PCI write, even with no transfer running
		cpu.wfifo_posted <= 1'b0;
		cpu.pfifo_posted <= 1'b1;
		cpu.req <= 1'b1;
		for (lat = 0; lat < 8; lat++) begin
			@(posedge clk);
			chk(32'(ack_n), 32'h1);
		end
		cpu.pfifo_posted <= 1'b0;
		for (lat = 0; ack_n !== 1'b0; lat++) begin
			@(posedge clk);
			lim(lat);
		end
		cpu.req <= 1'b0;
		// Hold, and control writes that must not disturb a run
		slow <= 1'b1;
		axw(fcd_pkg::ARB_OFF, 32'h0000_1000);
		n = ndone[1];
		c = GO | TOMEM | DONE_EN | 32'h0400_0000 | 32'd256;
		start(1, c, 32'h400);
		chk(32'(pout.channel), 32'h1);
		axw(fcd_pkg::CTL_OFF[1], 32'h0);
		axw(fcd_pkg::CTL_OFF[1], 32'h0800_0000);
		repeat (6) @(posedge clk);
		axr(fcd_pkg::WORDS_OFF);
		w = rd;
		repeat (20) @(posedge clk);
		axr(fcd_pkg::WORDS_OFF);
		chk(rd, w);
		chk(32'(pout.fill_req | pout.drain_req), 32'h0);
		axw(fcd_pkg::CTL_OFF[1], 32'h0);
		wait_idle(1);
		chk(rd, c & ~GO);
		chk(ndone[1] - n, 1);
		axr(fcd_pkg::CPCI_OFF);
		chk(rd, 32'h0000_1100);
		axr(fcd_pkg::CMEM_OFF);
		chk(rd, 32'h0000_0500);
		slow <= 1'b0;
		// Two-structure chain on channel 1
		axw(fcd_pkg::ARB_OFF, 32'h0000_0200);
		axr(fcd_pkg::ARB_OFF);
		chk(rd, 32'h0000_0209);
		axw(fcd_pkg::NXT_OFF[1], 32'h0000_0100);
		n = ndone[1];
		d0 = dcnt;
		start(1, GO | TOMEM | DONE_EN | 32'd16, 32'h0);
		for (lat = 0; dcnt < d0 + 4; lat++) begin
			@(posedge clk);
			lim(lat);
		end
		wait_idle(1);
		chk(dcnt - d0, 4);
		chk(dfirst, 32'h0000_0100);
		chk(ndone[1] - n, 1);
		// Chaining off, global interrupts off, memory to PCI
		axw(fcd_pkg::ARB_OFF, 32'h0000_2000);
		axw(fcd_pkg::NXT_OFF[1], 32'h0000_0100);
		cpu.irq_en <= 1'b0;
		start(1, GO | DONE_EN | 32'd16, 32'h0);
		chk(32'(pout.channel), 32'h1);
		chk(32'(pout.to_memory), 32'h0);
		wait_idle(1);
		chk(dcnt - d0, 4);
		chk(ndone[1] - n, 1);
		// Abort a full-megabyte transfer; kept last as the FIFO is not flushed
		start(2, GO | TOMEM | DONE_EN, 32'h0);
		axr(fcd_pkg::WORDS_OFF);
		chk(32'(rd > 32'h0003_FF00 && rd <= 32'h0004_0000), 32'h1);
		axw(fcd_pkg::CTL_OFF[2], 32'h0100_0000);
		repeat (4) @(posedge clk);
		axr(fcd_pkg::CTL_OFF[2]);
		chk(rd & 32'h9100_0000, 32'h0);
		test_done();
	end
endmodule : tb_fcd_dma

`default_nettype wire
